// ===== design/deep_sleep_if.sv
// Shared sleep request pin between the sequencer and its wake partner
// Assumes a pull-up on the pin: undriven reads as high (awake)
`timescale 1ns/1ps
`default_nettype none
interface deep_sleep_if;
    logic hostOut;
    logic hostOe;
    logic devOut;
    logic devOe;
    logic pinLevel;

    // -------------------------------------------------------------------
    // Wire resolution
    // -------------------------------------------------------------------
    // Device alarm driver wins; a board would not let both drive
    assign pinLevel = devOe ? devOut : (hostOe ? hostOut : 1'b1);

    modport device (input pinLevel, output devOut, output devOe);
    modport wake (input pinLevel, output hostOut, output hostOe);
endinterface
`default_nettype wire

// ===== design/deep_sleep_pkg.sv
// Constants, field layouts and state codes of the deep sleep sequencer
// Assumes one 100 MHz core clock and an active low asynchronous reset
//
// Overview of operation
// - Writing arm one clears the done flag
// - Clearing arm after wake clears done flag
// - Request pin ignored while arm is zero
// - Pin already low at arming: sleep at once
// - Sleep entry gates PLL reference clock first
// - Then oscillator disabled; external clock may run
// - Pin high again re-enables the oscillator
// - Wake counter counts valid oscillator cycles
// - Count reached: done set, clocks released
// - Programmed delay sets the stabilisation wait
// - Alarm output drives request, rises at alarm
// - Alarm output held low before the alarm
// - Field bits 31:28 select shared pin role
// - GPIO role still feeds the sleep request
// - Handshake: partner pulls line low, awaits arming
// - Partner drives line high to wake
// - Without handshake, partner waits for software before requesting
// - Software bypasses then powers down PLLs first
// - After wake, software powers up PLLs, leaves bypass
package deep_sleep_pkg;
    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] SLEEP_OFS = 8'h00;
    localparam logic [7:0] PIN_MUX_OFS = 8'h04;
    localparam logic [7:0] ALARM_OFS = 8'h08;
    localparam logic [7:0] RTC_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int ARM_BIT = 31;
    localparam int DONE_BIT = 30;
    localparam int DELAY_W = 16;
    localparam logic [15:0] DELAY_RST = 16'h0100;
    localparam int FN_LSB = 28;
    localparam logic [3:0] FN_SLEEP_IN = 4'h0;
    localparam logic [3:0] FN_ALARM = 4'h1;
    localparam logic [3:0] FN_GPIO = 4'h2;
    localparam logic [3:0] FN_RST = 4'h0;
    localparam logic [31:0] ALARM_RST = 32'hFFFFFFFF;
    localparam int ST_OSC_BIT = 2;
    localparam int ST_PLL_BIT = 3;
    localparam int ST_CLK_BIT = 4;
    localparam int ST_REQ_BIT = 5;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RTC_TICK_NS = 1000;
    localparam int RTC_DIV_CYCLES = RTC_TICK_NS / CLK_PERIOD_NS;

    // -------------------------------------------------------------------
    // State codes
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_GATE = 2'b01,
        ST_OSC_OFF = 2'b10,
        ST_WAKE = 2'b11
    } dev_state_t;

    typedef enum logic [1:0] {
        CT_IDLE = 2'b00,
        CT_WAIT_PREP = 2'b01,
        CT_LOW = 2'b10
    } ctl_state_t;
endpackage

// ===== design/deep_sleep_sequencer.sv
// Deep sleep sequencer: gates clocks, stops the oscillator, wakes on pin
// Assumes oscTick pulses once per valid oscillator cycle while it runs
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_sequencer (
    input wire logic core_clk,
    input wire logic rst_n,
    deep_sleep_if.device link,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic oscTick,
    output logic oscEnable,
    output logic pllRefEnable,
    output logic devClkEnable,
    output logic sleepActive
);
    import deep_sleep_pkg::*;

    dev_state_t state_reg;
    logic armBit_reg;
    logic doneFlag_reg;
    logic [DELAY_W-1:0] wakeDelay_reg;
    logic [DELAY_W-1:0] wakeCnt_reg;
    logic [3:0] pinFn_reg;
    logic [31:0] alarmTime_reg;
    logic [31:0] rtcCount_reg;
    logic [6:0] rtcDiv_reg;
    logic rtcTick;
    logic alarmFired_reg;
    logic reqSync;
    logic wrSleep;
    logic setDone;
    logic enterSleep;

    // -------------------------------------------------------------------
    // Request synchroniser
    // -------------------------------------------------------------------
    // Pin level feeds the request in every pin role, GPIO included
    sync_two_ff #(
        .RST_VAL(1'b1)
    ) u_reqSync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(link.pinLevel),
        .syncOut(reqSync)
    );

    assign wrSleep = regWr && (regAddr == SLEEP_OFS);
    // Done is also held off so a still-low pin cannot loop back to sleep
    assign enterSleep = armBit_reg && !reqSync && !doneFlag_reg;
    assign setDone = (state_reg == ST_WAKE) &&
        (wakeCnt_reg == wakeDelay_reg);

    // -------------------------------------------------------------------
    // Sleep sequence
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            oscEnable <= 1'b1;
            pllRefEnable <= 1'b1;
            devClkEnable <= 1'b1;
            sleepActive <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    // Arming with the pin already low enters at once
                    if (enterSleep) begin
                        state_reg <= ST_GATE;
                        pllRefEnable <= 1'b0;
                        devClkEnable <= 1'b0;
                        sleepActive <= 1'b1;
                    end
                end
                ST_GATE: begin
                    state_reg <= ST_OSC_OFF;
                    oscEnable <= 1'b0;
                end
                ST_OSC_OFF: begin
                    if (reqSync) begin
                        state_reg <= ST_WAKE;
                        oscEnable <= 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (setDone) begin
                        state_reg <= ST_RUN;
                        pllRefEnable <= 1'b1;
                        devClkEnable <= 1'b1;
                        sleepActive <= 1'b0;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Wake counter
    // -------------------------------------------------------------------
    // Counts only oscillator cycles flagged valid, not core cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeCnt_reg <= '0;
        end else if (state_reg != ST_WAKE) begin
            wakeCnt_reg <= '0;
        end else if (!setDone && oscTick) begin
            wakeCnt_reg <= wakeCnt_reg + 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Arm bit, delay and done flag
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armBit_reg <= 1'b0;
            wakeDelay_reg <= DELAY_RST;
        end else if (wrSleep) begin
            armBit_reg <= regWdata[ARM_BIT];
            wakeDelay_reg <= regWdata[DELAY_W-1:0];
        end
    end

    // A completion in the same cycle as a clearing write is kept
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            doneFlag_reg <= 1'b0;
        end else if (setDone) begin
            doneFlag_reg <= 1'b1;
        end else if (wrSleep && regWdata[ARM_BIT]) begin
            doneFlag_reg <= 1'b0;
        end else if (wrSleep && armBit_reg) begin
            doneFlag_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Pin role and alarm
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinFn_reg <= FN_RST;
        end else if (regWr && regAddr == PIN_MUX_OFS) begin
            pinFn_reg <= regWdata[FN_LSB+3:FN_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtcDiv_reg <= '0;
        end else if (rtcTick) begin
            rtcDiv_reg <= '0;
        end else begin
            rtcDiv_reg <= rtcDiv_reg + 1'b1;
        end
    end
    assign rtcTick = (rtcDiv_reg == 7'(RTC_DIV_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtcCount_reg <= '0;
        end else if (rtcTick) begin
            rtcCount_reg <= rtcCount_reg + 1'b1;
        end
    end

    // Rewriting the alarm time rearms the alarm low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmTime_reg <= ALARM_RST;
            alarmFired_reg <= 1'b0;
        end else if (regWr && regAddr == ALARM_OFS) begin
            alarmTime_reg <= regWdata;
            alarmFired_reg <= 1'b0;
        end else if (rtcCount_reg == alarmTime_reg) begin
            alarmFired_reg <= 1'b1;
        end
    end

    // Pin driven only in the alarm role; low until the alarm fires
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.devOut <= 1'b0;
            link.devOe <= 1'b0;
        end else begin
            link.devOut <= alarmFired_reg;
            link.devOe <= (pinFn_reg == FN_ALARM);
        end
    end

    // -------------------------------------------------------------------
    // Register read
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                SLEEP_OFS: begin
                    regRdata <= {armBit_reg, doneFlag_reg, 14'h0000,
                        wakeDelay_reg};
                end
                PIN_MUX_OFS: begin
                    regRdata <= {pinFn_reg, 28'h0000000};
                end
                ALARM_OFS: begin
                    regRdata <= alarmTime_reg;
                end
                RTC_OFS: begin
                    regRdata <= rtcCount_reg;
                end
                STATUS_OFS: begin
                    regRdata <= {26'h0000000, reqSync, devClkEnable,
                        pllRefEnable, oscEnable, state_reg};
                end
                default: begin
                    regRdata <= '0;
                end
            endcase
        end else begin
            regRdata <= '0;
        end
    end
endmodule
`default_nettype wire

// ===== design/sync_two_ff.sv
// Two flip-flop synchroniser for one level
// Assumes the input may change at any time relative to core_clk
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_reg;

    // -------------------------------------------------------------------
    // Stages
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// ===== design/wake_controller.sv
// External wake controller driving the shared sleep request pin
// Assumes software on the device signals prepDone once peripherals idle
`timescale 1ns/1ps
`default_nettype none
module wake_controller (
    input wire logic core_clk,
    input wire logic rst_n,
    deep_sleep_if.wake link,
    input wire logic driveEnable,
    input wire logic handshakeMode,
    input wire logic sleepReq,
    input wire logic wakeReq,
    input wire logic prepDone,
    output logic lineLow,
    output logic pinSeen
);
    import deep_sleep_pkg::*;

    ctl_state_t state_reg;

    // -------------------------------------------------------------------
    // Request sequence
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CT_IDLE;
            link.hostOut <= 1'b1;
            lineLow <= 1'b0;
        end else begin
            unique case (state_reg)
                CT_IDLE: begin
                    if (sleepReq && handshakeMode) begin
                        // The low line is itself the request to software
                        state_reg <= CT_LOW;
                        link.hostOut <= 1'b0;
                        lineLow <= 1'b1;
                    end else if (sleepReq) begin
                        state_reg <= CT_WAIT_PREP;
                    end
                end
                CT_WAIT_PREP: begin
                    if (wakeReq) begin
                        state_reg <= CT_IDLE;
                    end else if (prepDone) begin
                        state_reg <= CT_LOW;
                        link.hostOut <= 1'b0;
                        lineLow <= 1'b1;
                    end
                end
                CT_LOW: begin
                    if (wakeReq) begin
                        state_reg <= CT_IDLE;
                        link.hostOut <= 1'b1;
                        lineLow <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= CT_IDLE;
                    link.hostOut <= 1'b1;
                    lineLow <= 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Pin drive and observation
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.hostOe <= 1'b0;
            pinSeen <= 1'b1;
        end else begin
            link.hostOe <= driveEnable;
            pinSeen <= link.pinLevel;
        end
    end
endmodule
`default_nettype wire

// ===== verif/deep_sleep_checker.sv
// Assertions on the sleep pin and the sequencer's clock controls
// Assumes one core clock and rst_n as the only reset
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pinLevel,
    input wire logic devOe,
    input wire logic devOut,
    input wire logic oscEnable,
    input wire logic pllRefEnable,
    input wire logic devClkEnable,
    input wire logic sleepActive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // Entry and wake steps
    // ---------------------------------------------------------------
    sequence s_entry;
        $fell(pllRefEnable) && $fell(devClkEnable);
    endsequence
    sequence s_pin_low;
        (!oscEnable && !pinLevel) [*3];
    endsequence
    // Pin is sampled through two flops, hence the depth of three
    a_entry_order: assert property (
        s_entry |=> $fell(oscEnable))
        else $error("oscillator not stopped right after gating");
    a_gate_first: assert property (
        $fell(oscEnable) |-> !pllRefEnable)
        else $error("oscillator stopped before reference gated");
    a_entry_cause: assert property (
        $fell(devClkEnable) |-> !$past(pinLevel, 3))
        else $error("sleep entered with pin high");
    a_wake_cause: assert property (
        $rose(oscEnable) |-> $past(pinLevel, 3))
        else $error("oscillator restarted with pin low");
    a_osc_stays_off: assert property (
        s_pin_low |=> !oscEnable)
        else $error("oscillator restarted while pin low");
    a_wait_first: assert property (
        $rose(oscEnable) |-> !devClkEnable)
        else $error("clocks released with oscillator restart");
    a_release_all: assert property (
        $rose(devClkEnable) |-> pllRefEnable && oscEnable && !sleepActive)
        else $error("incomplete release at wake end");
    a_clock_pair: assert property (
        pllRefEnable == devClkEnable)
        else $error("reference and device clocks disagree");
    a_active_flag: assert property (
        sleepActive != devClkEnable)
        else $error("sleep flag out of step with clocks");
    a_alarm_low: assert property (
        $rose(devOe) |-> !devOut)
        else $error("alarm output high before alarm");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Testbench: sequencer and wake controller joined by the sleep pin
// Assumes the package offsets and role codes; oscTick made by the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import deep_sleep_pkg::*;
    logic core_clk, rst_n, regWr, regRd, oscTick;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rv;
    logic oscEnable, pllRefEnable, devClkEnable, sleepActive;
    logic driveEnable, handshakeMode, sleepReq, wakeReq, prepDone;
    logic lineLow, pinSeen;
    int bad_count, n_checks, n, tickDiv;
    deep_sleep_if link_if();
    deep_sleep_sequencer deep_sleep_sequencer_inst (.core_clk(core_clk),
        .rst_n(rst_n), .link(link_if), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .oscTick(oscTick), .oscEnable(oscEnable),
        .pllRefEnable(pllRefEnable), .devClkEnable(devClkEnable),
        .sleepActive(sleepActive));
    wake_controller wake_controller_inst (.core_clk(core_clk),
        .rst_n(rst_n), .link(link_if), .driveEnable(driveEnable),
        .handshakeMode(handshakeMode), .sleepReq(sleepReq),
        .wakeReq(wakeReq), .prepDone(prepDone), .lineLow(lineLow),
        .pinSeen(pinSeen));
    deep_sleep_checker deep_sleep_checker_inst (.core_clk(core_clk),
        .rst_n(rst_n), .pinLevel(link_if.pinLevel), .devOe(link_if.devOe),
        .devOut(link_if.devOut), .oscEnable(oscEnable),
        .pllRefEnable(pllRefEnable), .devClkEnable(devClkEnable),
        .sleepActive(sleepActive));
    // ---------------------------------------------------------------
    // Bus and handshake tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic pulse(input logic toSleep);
        @(posedge core_clk);
        if (toSleep) begin
            sleepReq <= 1'b1;
        end else begin
            wakeReq <= 1'b1;
        end
        @(posedge core_clk);
        sleepReq <= 1'b0;
        wakeReq <= 1'b0;
    endtask
    // Bounded wait on oscillator (sel 1) or device clock (sel 0)
    task automatic wait_for(input logic sel, input logic lvl, output int c);
        logic v;
        c = 0;
        v = ~lvl;
        while (v !== lvl) begin
            @(posedge core_clk);
            #1;
            v = sel ? oscEnable : devClkEnable;
            c++;
            if (c > 5000) begin
                bad_count++;
                close_out();
            end
        end
    endtask
    // One full sleep and wake through the wake controller
    task automatic sleep_cycle(input logic [3:0] role, input logic [15:0] dly);
        wr(PIN_MUX_OFS, {role, 28'h0});
        pulse(1'b1);
        repeat (6) @(posedge core_clk);
        #1;
        chk({link_if.pinLevel, lineLow, pinSeen}, 3'b010);
        chk(devClkEnable, 1'b1);
        wr(SLEEP_OFS, {16'h8000, dly});
        wait_for(1'b0, 1'b0, n);
        chk(n <= 3, 1'b1);
        chk({pllRefEnable, sleepActive}, 2'b01);
        rd(SLEEP_OFS, rv);
        chk(rv, {16'h8000, dly});
        pulse(1'b0);
        wait_for(1'b1, 1'b1, n);
        chk({lineLow, pinSeen, devClkEnable}, 3'b010);
        wait_for(1'b0, 1'b1, n);
        chk(n >= tickDiv * dly, 1'b1);
        chk(n <= tickDiv * dly + 2, 1'b1);
        rd(SLEEP_OFS, rv);
        chk(rv, {16'hC000, dly});
        // Re-arming with done set clears it; the pin is high, no entry
        wr(SLEEP_OFS, {16'h8000, dly});
        rd(SLEEP_OFS, rv);
        chk(rv, {16'h8000, dly});
        wr(SLEEP_OFS, {16'h0000, dly});
        rd(SLEEP_OFS, rv);
        chk(rv, {16'h0000, dly});
    endtask
    // ---------------------------------------------------------------
    // Clock, reset and main sequence
    // ---------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Valid oscillator ticks: every cycle, or every second one
    always @(posedge core_clk) begin
        oscTick <= (tickDiv == 2) ? ~oscTick : 1'b1;
    end
    initial begin
        rst_n = 1'b0;
        {regWr, regRd, sleepReq, wakeReq, prepDone} = 5'h00;
        regAddr = 8'h00;
        regWdata = 32'h0;
        tickDiv = 1;
        driveEnable = 1'b1;
        handshakeMode = 1'b1;
        bad_count = 0;
        n_checks = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk({oscEnable, pllRefEnable}, 2'b11);
        chk({devClkEnable, sleepActive}, 2'b10);
        rd(SLEEP_OFS, rv);
        chk(rv, {16'h0000, DELAY_RST});
        rd(8'h20, rv);
        chk(rv, 32'h0);
        // First pass: only every second cycle is a valid tick
        tickDiv = 2;
        sleep_cycle(FN_SLEEP_IN, 16'h0008);
        // Without handshake the line waits for the prepared signal
        @(posedge core_clk);
        tickDiv = 1;
        handshakeMode <= 1'b0;
        pulse(1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        chk({link_if.pinLevel, lineLow}, 2'b10);
        pulse(1'b0);
        prepDone <= 1'b1;
        sleep_cycle(FN_GPIO, 16'h0000);
        // Re-arm and disarm with the pin high: no entry
        wr(SLEEP_OFS, 32'h8000_0000);
        rd(SLEEP_OFS, rv);
        chk(rv, 32'h8000_0000);
        wr(SLEEP_OFS, 32'h0);
        // Alarm wake: pin owned by the device, host released
        @(posedge core_clk);
        driveEnable <= 1'b0;
        rd(RTC_OFS, rv);
        wr(ALARM_OFS, rv + 32'h3);
        wr(PIN_MUX_OFS, {FN_ALARM, 28'h0});
        // Output enable follows the role register one cycle later
        @(posedge core_clk);
        #1;
        chk({link_if.devOe, link_if.pinLevel}, 2'b10);
        rd(PIN_MUX_OFS, rv);
        chk(rv, {FN_ALARM, 28'h0});
        wr(SLEEP_OFS, 32'h8000_0004);
        wait_for(1'b0, 1'b0, n);
        chk(n <= 3, 1'b1);
        wait_for(1'b0, 1'b1, n);
        chk(n >= 150 && link_if.pinLevel === 1'b1, 1'b1);
        rd(SLEEP_OFS, rv);
        chk(rv, 32'hC000_0004);
        wr(SLEEP_OFS, 32'h0);
        rd(SLEEP_OFS, rv);
        chk(rv, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
